// [hw/sbs_params.svh]
// constants for the synchronous burst sram control block
//
// Functional notes
// RULE_01 - check write data parity every write; flow-through reports the following cycle
// RULE_02 - pipeline mode reports a write parity error one cycle later than flow-through
// RULE_03 - system holds parity select high for even parity, low for odd parity
// RULE_04 - read data parity is never checked by the device
// RULE_05 - error flag is open drain, pulled low only while an error is reported
// RULE_06 - idle mode inputs mean interleaved, pipeline, even parity, awake; low selects others; here the sleep request sleeps when high, is awake when low
// RULE_07 - linear order adds one to the low address bits, modulo four
// RULE_08 - interleaved order xors the loaded low bits with a 0..3 count
// RULE_09 - global write writes all bytes; else master write writes low-enabled lanes
// RULE_10 - no write decode means read, and every byte output is active
// RULE_11 - all data drivers stay off during any write
// RULE_12 - lanes c and d exist only in the four-lane configuration
// RULE_13 - deselect with drivers off for the two listed enable and strobe combinations
// RULE_14 - enabled processor strobe starts a read burst; ignored when low enable high
// RULE_15 - enabled controller strobe alone starts a burst, write if decode true
// RULE_16 - no start and advance low: access next burst address
// RULE_17 - no start and advance high: hold counter, access current address
// RULE_18 - output enable high turns drivers off; low only passes read drivers
// RULE_19 - simple non-burst use holds processor strobe high, controller strobe low
// RULE_20 - simple burst use holds processor strobe high, advance low
// RULE_21 - a dummy read advances the burst counter like any read
// RULE_22 - sleep request high enters low power, memory contents kept
// RULE_23 - burst start loads counter from low address bits, holds upper bits
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH

// ------------------------------------------------------------
// geometry
// ------------------------------------------------------------
`define SBS_ADDR_W     18
`define SBS_LANES      4
`define SBS_LANE_BITS  9
`define SBS_LOW_BITS   2

// ------------------------------------------------------------
// reset and step values
// ------------------------------------------------------------
`define SBS_RST_LOW    2'h0
`define SBS_CNT_STEP   2'h1

`endif

// [hw/sbs_pkg.sv]
// types of the synchronous burst sram control block
package sbs_pkg;
  typedef enum logic [1:0] {
    SBS_OP_IDLE  = 2'b00,
    SBS_OP_READ  = 2'b01,
    SBS_OP_WRITE = 2'b10,
    SBS_OP_DESEL = 2'b11
  } sbs_op_t;
endpackage

// [hw/sbs_burst_counter.sv]
// two-bit burst address counter, linear or interleaved
`include "sbs_params.svh"
module sbs_burst_counter
  import sbs_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic       load_in,
  input  wire logic [1:0] load_val_in,
  input  wire logic       step_in,
  input  wire logic       linear_in,
  output logic      [1:0] cur_low_out,
  output logic      [1:0] next_low_out
);
  logic [1:0] start_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_nx;

  assign cnt_nx = cnt_q + `SBS_CNT_STEP;
  // RULE_07 linear sum
  // RULE_08 interleaved xor
  assign cur_low_out  = linear_in ? start_q + cnt_q  : start_q ^ cnt_q;
  assign next_low_out = linear_in ? start_q + cnt_nx : start_q ^ cnt_nx;

  // RULE_23 load on start
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      start_q <= `SBS_RST_LOW;
      cnt_q   <= `SBS_RST_LOW;
    end else if (load_in) begin
      start_q <= load_val_in;
      cnt_q   <= `SBS_RST_LOW;
    end else if (step_in) begin
      cnt_q <= cnt_nx;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_wrap_four: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RULE_07
    (!load_in && step_in) [*4] |=> cur_low_out == $past(cur_low_out, 4))
    else $error("burst counter did not wrap after four steps");
endmodule

// [hw/sbs_ctrl.sv]
// synchronous control logic of a burst static ram
//
// The address-and-strobe port was decided locally.
`include "sbs_params.svh"
module sbs_ctrl
  import sbs_pkg::*;
#(
  parameter int ADDR_W    = `SBS_ADDR_W,
  parameter int LANES     = `SBS_LANES,
  parameter int LANE_BITS = `SBS_LANE_BITS
) (
  input  wire logic                       ref_clk_in,
  input  wire logic                       reset_in,
  input  wire logic [ADDR_W-1:0]          addr_in,
  input  wire logic                       chip_sel_low_active_in,
  input  wire logic                       chip_sel_high_active_in,
  input  wire logic                       processor_addr_strobe_n_in,
  input  wire logic                       controller_addr_strobe_n_in,
  input  wire logic                       burst_advance_n_in,
  input  wire logic                       global_write_n_in,
  input  wire logic                       lane_write_master_n_in,
  input  wire logic [LANES-1:0]           lane_write_n_in,
  input  wire logic                       output_enable_n_in,
  input  wire logic                       sleep_request_in,
  input  wire logic                       flow_through_select_n_in,
  input  wire logic                       burst_order_select_n_in,
  input  wire logic                       parity_polarity_select_in,
  input  wire logic [LANES*LANE_BITS-1:0] dq_in,
  output logic      [LANES*LANE_BITS-1:0] dq_out,
  output logic      [LANES-1:0]           dq_oe_out,
  input  wire logic                       parity_error_flag_n_in,
  output logic                            parity_error_flag_n_out,
  output logic                            parity_error_flag_n_oe_out,
  output logic      [ADDR_W-1:0]          mem_addr_out,
  output logic                            mem_read_out,
  output logic      [LANES-1:0]           mem_byte_we_out,
  output logic      [LANES*LANE_BITS-1:0] mem_wdata_out,
  input  wire logic [LANES*LANE_BITS-1:0] mem_rdata_in,
  output logic      [1:0]                 last_op_out,
  output logic                            low_power_out
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // RULE_12 two or four lanes
  if (LANES != 2 && LANES != 4) begin : g_bad_lanes
    $error("LANES must be 2 or 4");
  end
  if (ADDR_W < 3) begin : g_bad_addr
    $error("ADDR_W must be at least 3");
  end
  if (LANE_BITS < 2) begin : g_bad_lane_bits
    $error("LANE_BITS must be at least 2");
  end

  // ------------------------------------------------------------
  // mode pins
  // ------------------------------------------------------------
  // RULE_06 pulled-up pins read high
  wire linear_mode  = !burst_order_select_n_in;
  wire flow_through = !flow_through_select_n_in;
  wire odd_parity   = !parity_polarity_select_in;
  wire asleep       = sleep_request_in;

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  wire             any_lane_low = !(&lane_write_n_in);
  // RULE_09 global or per-lane write
  wire             write_dec    = !global_write_n_in || (!lane_write_master_n_in && any_lane_low);
  wire [LANES-1:0] lane_en      = !global_write_n_in ? {LANES{1'b1}} :
                                  (!lane_write_master_n_in ? ~lane_write_n_in : '0);

  // ------------------------------------------------------------
  // cycle decode
  // ------------------------------------------------------------
  wire enabled   = !chip_sel_low_active_in && chip_sel_high_active_in;
  wire processor_addr_strobe      = !processor_addr_strobe_n_in;
  wire controller_addr_strobe      = !controller_addr_strobe_n_in;
  // RULE_13 two deselect cases
  wire deselect  = (chip_sel_low_active_in && controller_addr_strobe) ||
                   (!chip_sel_low_active_in && !chip_sel_high_active_in && (processor_addr_strobe || controller_addr_strobe));
  // RULE_14 processor strobe start
  wire start_p   = enabled && processor_addr_strobe;
  // RULE_15 controller strobe start
  wire start_c   = enabled && !processor_addr_strobe && controller_addr_strobe;
  wire start     = start_p || start_c;
  // RULE_16 continue when no strobe starts
  wire cont      = !controller_addr_strobe && (!processor_addr_strobe || chip_sel_low_active_in);
  wire burst_advance       = cont && !burst_advance_n_in;
  wire op_write  = (start_c || cont) && write_dec;
  // RULE_10 read when no write decode
  wire op_read   = start_p || ((start_c || cont) && !write_dec);

  // sleep blocks every access; the counter keeps its place so memory state is untouched
  wire do_read   = !asleep && op_read;
  wire do_write  = !asleep && op_write;
  wire do_start  = !asleep && start;
  wire do_adv    = !asleep && burst_advance;

  sbs_op_t op_now;
  assign op_now = asleep   ? SBS_OP_IDLE  :
                  deselect ? SBS_OP_DESEL :
                  op_write ? SBS_OP_WRITE :
                  op_read  ? SBS_OP_READ  : SBS_OP_IDLE;

  // ------------------------------------------------------------
  // burst address
  // ------------------------------------------------------------
  logic [1:0]        cur_low;
  logic [1:0]        next_low;
  logic [ADDR_W-3:0] upper_q;
  logic [ADDR_W-3:0] upper_d;
  logic [1:0]        low_used;

  // RULE_21 dummy reads step too, output enable not involved
  sbs_burst_counter u_cnt (
    .ref_clk_in   (ref_clk_in),
    .reset_in     (reset_in),
    .load_in      (do_start),
    .load_val_in  (addr_in[1:0]),
    .step_in      (do_adv),
    .linear_in    (linear_mode),
    .cur_low_out  (cur_low),
    .next_low_out (next_low)
  );

  // RULE_23 upper bits latched at start
  assign upper_d  = do_start ? addr_in[ADDR_W-1:2] : upper_q;
  // RULE_17 suspend reuses current address
  assign low_used = do_start ? addr_in[1:0] : (do_adv ? next_low : cur_low);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      upper_q <= '0;
    end else begin
      upper_q <= upper_d;
    end
  end

  // ------------------------------------------------------------
  // memory side strobes
  // ------------------------------------------------------------
  logic [ADDR_W-1:0]          mem_addr_q;
  logic                       mem_read_q;
  logic [LANES-1:0]           mem_we_q;
  logic [LANES*LANE_BITS-1:0] mem_wdata_q;
  logic [1:0]                 last_op_q;
  logic                       low_power_q;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      mem_addr_q  <= '0;
      mem_read_q  <= 1'b0;
      mem_we_q    <= '0;
      mem_wdata_q <= '0;
      last_op_q   <= SBS_OP_IDLE;
      low_power_q <= 1'b0;
    end else begin
      mem_addr_q  <= {upper_d, low_used};
      mem_read_q  <= do_read;
      mem_we_q    <= do_write ? lane_en : '0;
      mem_wdata_q <= dq_in;
      last_op_q   <= op_now;
      // RULE_22 low power flag
      low_power_q <= asleep;
    end
  end

  assign mem_addr_out    = mem_addr_q;
  assign mem_read_out    = mem_read_q;
  assign mem_byte_we_out = mem_we_q;
  assign mem_wdata_out   = mem_wdata_q;
  assign last_op_out     = last_op_q;
  assign low_power_out   = low_power_q;

  // ------------------------------------------------------------
  // data drivers
  // ------------------------------------------------------------
  // output enable is sampled, so drivers drop one edge after it rises, not at once
  logic                       rd_d1_q;
  logic [LANES-1:0]           oe_q;
  logic [LANES*LANE_BITS-1:0] dq_q;
  logic                       read_slot;

  assign read_slot = flow_through ? mem_read_q : rd_d1_q;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rd_d1_q <= 1'b0;
      oe_q    <= '0;
      dq_q    <= '0;
    end else begin
      rd_d1_q <= mem_read_q && !deselect;
      // RULE_11 writes force drivers off
      // RULE_18 output enable only gates read drivers
      oe_q    <= (read_slot && !output_enable_n_in && !do_write && !deselect) ?
                 {LANES{1'b1}} : '0;
      dq_q    <= mem_rdata_in;
    end
  end

  assign dq_oe_out = oe_q;
  assign dq_out    = dq_q;

  // ------------------------------------------------------------
  // write parity check
  // ------------------------------------------------------------
  logic [LANES-1:0] lane_bad;

  // RULE_03 polarity pin picks even or odd
  for (genvar i = 0; i < LANES; i++) begin : g_par
    assign lane_bad[i] = (^dq_in[i*LANE_BITS +: LANE_BITS]) ^ odd_parity;
  end

  // RULE_04 only write lanes are checked
  wire par_err_now = do_write && |(lane_bad & lane_en);

  // the check result is staged like read data, so the flag lines up with the output timing
  logic par_d1_q;
  logic par_d2_q;
  logic flag_q;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      par_d1_q <= 1'b0;
      par_d2_q <= 1'b0;
      flag_q   <= 1'b0;
    end else begin
      par_d1_q <= par_err_now;
      par_d2_q <= par_d1_q;
      // RULE_01 flow-through, next cycle
      // RULE_02 pipeline, one cycle later
      flag_q   <= flow_through ? par_d1_q : par_d2_q;
    end
  end

  // RULE_05 open drain pulls low only
  assign parity_error_flag_n_out    = 1'b0;
  assign parity_error_flag_n_oe_out = flag_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  a_parity_ft: assert property ( // RULE_01
    flow_through [*3] ##0 $past(par_err_now, 2) |-> parity_error_flag_n_oe_out)
    else $error("flow-through parity error not flagged next cycle");

  a_parity_pipe: assert property ( // RULE_02
    !flow_through [*4] ##0 $past(par_err_now, 3) |-> parity_error_flag_n_oe_out)
    else $error("pipeline parity error not flagged two cycles later");

  a_parity_quiet: assert property ( // RULE_04
    !$past(do_write, 2) && !$past(do_write, 3) |-> !parity_error_flag_n_oe_out)
    else $error("parity error flagged without a write");

  a_flag_drain: assert property ( // RULE_05
    parity_error_flag_n_oe_out |-> !parity_error_flag_n_out)
    else $error("error flag driven high");

  a_flag_pin: assert property ( // RULE_05
    parity_error_flag_n_oe_out |-> !parity_error_flag_n_in)
    else $error("error pin not low while flag driven");

  a_advance_next: assert property ( // RULE_16
    do_start ##1 do_adv |=> mem_addr_out[1:0] == ($past(linear_mode) ?
      $past(mem_addr_out[1:0]) + `SBS_CNT_STEP : $past(mem_addr_out[1:0]) ^ `SBS_CNT_STEP))
    else $error("burst advance did not step the low address bits");

  a_dummy_step: assert property ( // RULE_21
    (do_start || do_adv) ##1 (do_adv && output_enable_n_in) |=>
      mem_addr_out[1:0] != $past(mem_addr_out[1:0]))
    else $error("dummy read did not advance the burst address");

  a_read_drivers: assert property ( // RULE_10
    flow_through && mem_read_out && op_read && !output_enable_n_in |=>
      dq_oe_out == {LANES{1'b1}})
    else $error("read did not enable every byte driver");

  a_write_lanes: assert property ( // RULE_09
    do_write && !global_write_n_in |=> mem_byte_we_out == {LANES{1'b1}})
    else $error("global write did not write every lane");

  a_read_decode: assert property ( // RULE_14
    start_p && !asleep |=> mem_read_out && mem_byte_we_out == '0)
    else $error("processor strobe start not a read");

  a_write_hiz: assert property ( // RULE_11
    do_write |=> dq_oe_out == '0)
    else $error("drivers on during a write");

  a_desel_hiz: assert property ( // RULE_13
    deselect |=> dq_oe_out == '0 && !mem_read_out && mem_byte_we_out == '0)
    else $error("deselect left an access or driver active");

  a_start_addr: assert property ( // RULE_15
    start_c && !asleep |=> mem_addr_out == $past(addr_in))
    else $error("controller strobe start used wrong address");

  a_suspend_hold: assert property ( // RULE_17
    (do_start || do_adv) ##1 (cont && burst_advance_n_in && !asleep)
      |=> mem_addr_out == $past(mem_addr_out))
    else $error("suspended burst moved the address");

  a_oe_gate: assert property ( // RULE_18
    $past(output_enable_n_in) |-> dq_oe_out == '0)
    else $error("drivers on with output enable high");

  a_sleep_idle: assert property ( // RULE_22
    asleep |=> !mem_read_out && mem_byte_we_out == '0 && low_power_out)
    else $error("access during sleep");

  c_read_burst: cover property (
    start_p ##1 (cont && !burst_advance_n_in) [*3]);

  c_write_burst: cover property (
    start_c && write_dec ##1 (cont && !burst_advance_n_in && write_dec) [*3]);

  c_parity_flag: cover property (parity_error_flag_n_oe_out);

  c_dummy_read: cover property (op_read && output_enable_n_in ##1 op_write);

  c_suspend: cover property (do_adv ##1 (cont && burst_advance_n_in && !asleep));

endmodule

// [verif/sbs_cpu_model.sv]
// processor side model driving the burst sram control pins
module sbs_cpu_model (
  input  wire logic [2:0]  cmd_in,
  input  wire logic        write_in,
  input  wire logic        all_in,
  input  wire logic [3:0]  lanes_n_in,
  input  wire logic [3:0]  bad_in,
  input  wire logic        even_in,
  input  wire logic [17:0] addr_in,
  input  wire logic [31:0] data_in,
  output logic             sel_lo_out,
  output logic             sel_hi_out,
  output logic             pstb_n_out,
  output logic             cstb_n_out,
  output logic             step_n_out,
  output logic             allw_n_out,
  output logic             mstw_n_out,
  output logic [3:0]       lane_n_out,
  output logic [35:0]      dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       spare;
  logic [4:0] pins;
  // ------------------------------------------------------------
  // cycle command to pin levels
  // ------------------------------------------------------------
  // don't-care pins follow a spare address bit so both levels occur
  assign spare = addr_in[17];
  // strobe levels for each cycle kind
  always_comb begin
    case (cmd_in)
      3'h0: pins = {1'h1, 1'h1, spare, 1'h0, spare};
      3'h1: pins = {1'h0, 1'h0, 1'h0, spare, spare};
      3'h2: pins = {1'h0, 1'h0, 1'h1, 1'h0, spare};
      3'h3: pins = {1'h0, 1'h1, 1'h0, spare, spare};
      3'h4: pins = {1'h0, 1'h1, 1'h1, 1'h0, spare};
      3'h5: pins = {spare, 1'h1, 1'h1, 1'h1, 1'h0};
      3'h6: pins = {spare, 1'h1, 1'h1, 1'h1, 1'h1};
      default: pins = {1'h1, spare, 1'h0, 1'h1, 1'h0};
    endcase
  end
  assign {sel_lo_out, sel_hi_out, pstb_n_out, cstb_n_out, step_n_out} = pins;
  assign allw_n_out = ~(write_in & all_in);
  assign mstw_n_out = ~(write_in & ~all_in);
  assign lane_n_out = lanes_n_in;
  // ------------------------------------------------------------
  // write data with lane parity
  // ------------------------------------------------------------
  // parity bit even when select high, odd when low; bad lanes flipped
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign dq_out[9*i+:9] = {^data_in[8*i+:8] ^ ~even_in ^ bad_in[i], data_in[8*i+:8]};
  end
endmodule

// [verif/sync_burst_sram_control_test.sv]
// self-checking bench of the burst sram control block
module sync_burst_sram_control_test import sbs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_in, reset_in, m_pipe, m_ilv, m_even, m_off, m_sleep;
  logic [12:0] req;
  logic [4:0]  mode_r;
  logic [17:0] addr_r, maddr, p_addr;
  logic [31:0] data_r;
  logic [35:0] rdata_r, dq_w, wd_w, rd_o, p_wd, p_rdd;
  logic        sel_lo, sel_hi, pstb_n, cstb_n, step_n, allw_n, mstw_n;
  logic        rd_w, fl_o, fl_oe, low_w, fl_pin, p_rd, p_wr, p_sleep;
  logic [3:0]  lane_n, oe_w, we_w, fl, fo, p_we;
  logic [1:0]  op_w, st, cnt;
  logic [15:0] rnd, up;
  sbs_op_t     p_op;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          quiet = 9;
  // open drain flag shares a board pull-up
  assign fl_pin = fl_oe ? fl_o : 1'h1;
  sbs_cpu_model sbs_cpu_model_i (.cmd_in(req[12:10]), .write_in(req[9]), .all_in(req[8]),
    .lanes_n_in(req[7:4]), .bad_in(req[3:0]), .even_in(mode_r[2]), .addr_in(addr_r),
    .data_in(data_r), .sel_lo_out(sel_lo), .sel_hi_out(sel_hi), .pstb_n_out(pstb_n),
    .cstb_n_out(cstb_n), .step_n_out(step_n), .allw_n_out(allw_n), .mstw_n_out(mstw_n),
    .lane_n_out(lane_n), .dq_out(dq_w));
  sbs_ctrl #(.ADDR_W(18), .LANES(4), .LANE_BITS(9)) sbs_ctrl_i (.ref_clk_in(ref_clk_in),
    .reset_in(reset_in), .addr_in(addr_r), .chip_sel_low_active_in(sel_lo),
    .chip_sel_high_active_in(sel_hi), .processor_addr_strobe_n_in(pstb_n),
    .controller_addr_strobe_n_in(cstb_n), .burst_advance_n_in(step_n),
    .global_write_n_in(allw_n), .lane_write_master_n_in(mstw_n), .lane_write_n_in(lane_n),
    .output_enable_n_in(mode_r[1]), .sleep_request_in(mode_r[0]),
    .flow_through_select_n_in(mode_r[4]), .burst_order_select_n_in(mode_r[3]),
    .parity_polarity_select_in(mode_r[2]), .dq_in(dq_w), .dq_out(rd_o), .dq_oe_out(oe_w),
    .parity_error_flag_n_in(fl_pin), .parity_error_flag_n_out(fl_o),
    .parity_error_flag_n_oe_out(fl_oe), .mem_addr_out(maddr), .mem_read_out(rd_w),
    .mem_byte_we_out(we_w), .mem_wdata_out(wd_w), .mem_rdata_in(rdata_r), .last_op_out(op_w),
    .low_power_out(low_w));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // write word as the pins carry it: each lane has its parity bit on top
  function automatic logic [35:0] wimg(input logic [31:0] d, input logic [3:0] b, input logic ev);
    for (int i = 0; i < 4; i++) wimg[9*i+:9] = {^d[8*i+:8] ^ ~ev ^ b[i], d[8*i+:8]};
  endfunction
  function automatic logic [1:0] cur_low(input logic [1:0] s, input logic [1:0] c);
    return m_ilv ? (s ^ c) : (s + c);
  endfunction
  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  // drive one cycle, then check what the previous cycle produced
  task automatic go(input logic [2:0] c, input logic w, input logic al,
                    input logic [3:0] ln, input logic [3:0] bd, input logic [1:0] lo);
    logic       wdec, wr, rd, ds;
    logic [3:0] we_e;
    @(posedge ref_clk_in);
    rnd = lfsr(rnd);
    req <= {c, w, al, ln, bd};
    mode_r <= {m_pipe, m_ilv, m_even, m_off, m_sleep};
    addr_r <= {rnd, lo};
    data_r <= {rnd, ~rnd};
    rdata_r <= {rnd[3:0], rnd, ~rnd};
    wdec = w & (al | ln != 4'hF);
    we_e = wdec ? (al ? 4'hF : ~ln) : 4'h0;
    ds = c < 3'h3;
    wr = !ds & c != 3'h3 & wdec & !m_sleep;
    rd = !ds & !wr & !m_sleep;
    if (!m_sleep & (c == 3'h3 | c == 3'h4)) begin
      st = lo;
      cnt = 2'h0;
      up = rnd;
    end else if (!m_sleep & (c == 3'h5 | c == 3'h7)) cnt = cnt + 2'h1;
    #1;
    chk(rd_w, p_rd, "read strobe");
    chk(we_w, p_we, "lane strobes");
    if (p_rd | p_wr) chk(maddr, p_addr, "address");
    if (!p_sleep) chk(op_w, p_op, "cycle kind");
    chk(low_w, p_sleep, "low power");
    chk(wd_w, p_wd, "write data");
    chk(rd_o, p_rdd, "read data");
    chk({fl_oe, fl_pin}, {fl[0], !fl[0]}, "parity flag");
    if (fo[0] | p_wr | quiet > 2) chk(oe_w, {4{fo[0]}}, "drivers");
    fl = fl >> 1;
    fo = fo >> 1;
    if (wr & |(bd & we_e)) fl[m_pipe ? 2 : 1] = 1'h1;
    if (rd & !m_off) begin
      fo[m_pipe ? 2 : 1] = 1'h1;
      quiet = 0;
    end else begin
      fo = 4'h0;
      quiet = m_sleep ? 0 : quiet + 1;
    end
    p_rd = rd;
    p_wr = wr;
    p_we = wr ? we_e : 4'h0;
    p_sleep = m_sleep;
    p_addr = {up, cur_low(st, cnt)};
    p_op = ds ? SBS_OP_DESEL : (wr ? SBS_OP_WRITE : SBS_OP_READ);
    p_wd = wimg({rnd, ~rnd}, bd, m_even);
    p_rdd = {rnd[3:0], rnd, ~rnd};
  endtask
  task automatic plain(input logic [2:0] c, input int n);
    repeat (n) go(c, 1'h0, 1'h0, 4'hF, 4'h0, 2'h0);
  endtask
  // ------------------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk_in = 1'h0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    reset_in = 1'h1;
    req = 13'h0F0;
    {m_pipe, m_ilv, m_even, m_off, m_sleep} = 5'h1C;
    mode_r = 5'h1C;
    {addr_r, data_r, rdata_r, st, cnt, up, fl, fo, p_we, p_addr, p_wd, p_rdd} = '0;
    {p_rd, p_wr, p_sleep} = 3'h0;
    p_op = SBS_OP_DESEL;
    rnd = 16'h004C;
    repeat (7) @(posedge ref_clk_in);
    #1;
    chk({rd_w, we_w, oe_w, fl_oe, op_w, low_w}, 36'h0, "reset state");
    @(posedge ref_clk_in);
    reset_in <= 1'h0;
    for (int m = 0; m < 4; m++) begin
      plain(3'h0, 3);
      m_pipe = m[0];
      m_ilv = m[1];
      for (int s = 0; s < 4; s++) begin
        go(3'(4 - s % 2), 1'h0, 1'h0, 4'hF, 4'h0, 2'(s));
        plain(3'h5, 4);
        plain(3'h6, 1);
        plain(3'h7, 1);
      end
    end
    done("burst order");
    for (int m = 0; m < 4; m++) begin
      plain(3'h0, 3);
      m_pipe = m[0];
      m_even = m[1];
      m_ilv = rnd[0];
      go(3'h4, 1'h1, 1'h0, 4'hF, 4'hF, rnd[2:1]);
      go(3'h4, 1'h1, 1'h1, 4'hF, 4'h8, rnd[2:1]);
      go(3'h3, 1'h1, 1'h1, 4'h0, 4'h2, rnd[2:1]);
      repeat (40) go(3'(3 + rnd[2:0] % 5), rnd[3], rnd[4], rnd[8:5],
                     rnd[12:9] & {4{rnd[13]}}, rnd[15:14]);
    end
    done("write decode and parity");
    for (int k = 0; k < 3; k++) begin
      go(3'h4, 1'h0, 1'h0, 4'hF, 4'h0, 2'h1);
      plain(3'h5, 1);
      plain(3'(k), 3);
    end
    done("deselect");
    m_off = 1'h1;
    go(3'h4, 1'h0, 1'h0, 4'hF, 4'h0, 2'h2);
    plain(3'h5, 4);
    m_off = 1'h0;
    plain(3'h5, 3);
    done("dummy read");
    go(3'h4, 1'h0, 1'h0, 4'hF, 4'h0, 2'h3);
    m_sleep = 1'h1;
    plain(3'h5, 3);
    go(3'h4, 1'h1, 1'h1, 4'h0, 4'hF, 2'h0);
    m_sleep = 1'h0;
    plain(3'h6, 2);
    done("sleep");
    summarize();
  end
endmodule
